// ---- include/dac_smbus_pkg.sv ----
// constants, state encoding and field layout for the two-wire dac write slave
package dac_smbus_pkg;

  // ----------------------------------------------------------------
  // address matching
  // ----------------------------------------------------------------
  localparam logic [3:0] OWN_ADDR_UPPER = 4'h4;
  localparam logic [6:0] GROUP_ADDR = 7'h7E;
  localparam logic WRITE_DIR = 1'h0;

  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_GROUP_BIT = 0;
  localparam int CMD_POWER_BIT = 1;
  localparam int CMD_REF_BIT = 2;

  // ----------------------------------------------------------------
  // byte and bit counting
  // ----------------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BYTE_ADDR = 3'h0;
  localparam logic [2:0] BYTE_CMD = 3'h1;
  localparam logic [2:0] BYTE_LOW = 3'h2;
  localparam logic [2:0] BYTE_HIGH = 3'h3;
  localparam logic [2:0] BYTE_EXTRA = 3'h4;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int CODE_WIDTH = 10;
  localparam int HIGH_CODE_BITS = 2;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] COUNT_RESET = 3'h0;

  // ----------------------------------------------------------------
  // pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int PIN_WIDTH = 6;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_TOGGLE = 2;
  localparam int PIN_ADDR_LSB = 3;
  localparam int ADDR_PINS = 3;
  localparam logic [5:0] PIN_IDLE = 6'h03;

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT = 3'b001,
    ST_ACK_WAIT = 3'b010,
    ST_ACK_DRIVE = 3'b011,
    ST_ACK_HOLD = 3'b100,
    ST_IGNORE = 3'b101
  } link_state_type;

endpackage

// ---- verilog/dac_smbus_write_slave.sv ----
// receive-only two-wire slave front end for a 10-bit voltage dac
`timescale 1ns/1ps
`default_nettype none

module dac_smbus_write_slave
  import dac_smbus_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_link,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_2,
  input wire logic addr_select_pin_1,
  input wire logic addr_select_pin_0,
  output logic [CODE_WIDTH-1:0] dac_code,
  output logic reference_select,
  output logic power_down_select,
  output logic group_update_select,
  output logic bus_busy
);

  // ----------------------------------------------------------------
  // link clock domain: bit capture
  // ----------------------------------------------------------------
  // the link clock only runs inside frames, so these flops start from
  // a constant and the system side resynchronises its view at reset
  logic link_bit = 1'b1;
  logic link_toggle = 1'b0;

  always_ff @(posedge scl_link) begin
    link_bit <= sda_in;
    link_toggle <= ~link_toggle;
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_WIDTH-1:0] pin_raw;
  logic [PIN_WIDTH-1:0] pin_s1;
  logic [PIN_WIDTH-1:0] pin_s2;
  logic [PIN_WIDTH-1:0] pin_s3;
  logic [PIN_WIDTH-1:0] pin_agree;
  logic [PIN_WIDTH-1:0] pin_level;
  logic [PIN_WIDTH-1:0] pin_prev;
  logic [PIN_WIDTH-1:0] next_pin_level;

  assign pin_raw = {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, link_toggle, sda_in, scl_link};
  assign pin_agree = ~(pin_s2 ^ pin_s3);
  assign next_pin_level = (pin_s2 & pin_agree) | (pin_level & ~pin_agree);

  always_ff @(posedge clk_sys) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_level <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      pin_level <= next_pin_level;
      pin_prev <= pin_level;
    end
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic scl_held_high;
  logic start_evt;
  logic stop_evt;
  logic scl_fall;
  logic bit_evt;
  logic frame_edge;

  assign scl_held_high = pin_level[PIN_SCL] & pin_prev[PIN_SCL];
  assign start_evt = scl_held_high & pin_prev[PIN_SDA] & ~pin_level[PIN_SDA];
  assign stop_evt = scl_held_high & ~pin_prev[PIN_SDA] & pin_level[PIN_SDA];
  assign scl_fall = pin_prev[PIN_SCL] & ~pin_level[PIN_SCL];
  assign bit_evt = pin_level[PIN_TOGGLE] ^ pin_prev[PIN_TOGGLE];
  assign frame_edge = start_evt | stop_evt;

  // ----------------------------------------------------------------
  // byte assembly and address decode
  // ----------------------------------------------------------------
  link_state_type state;
  link_state_type next_state;
  logic [2:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic shift_evt;
  logic byte_done;
  logic [6:0] own_addr;
  logic own_match;
  logic group_match;
  logic group_hit;
  logic own_hit;
  logic group_action_bit;
  logic byte_accept;
  logic ack_rise;
  logic in_shift;
  logic in_ack_drive;
  logic in_ack_hold;
  logic ack_end;
  logic at_addr_byte;
  logic at_cmd_byte;
  logic at_low_byte;
  logic at_high_byte;
  logic data_room;
  logic addr_done;

  assign own_addr = {OWN_ADDR_UPPER, pin_level[PIN_ADDR_LSB +: ADDR_PINS]};
  assign next_shift = {shift[6:0], link_bit};
  assign in_shift = (state == ST_SHIFT);
  assign in_ack_drive = (state == ST_ACK_DRIVE);
  assign in_ack_hold = (state == ST_ACK_HOLD);
  assign ack_end = in_ack_hold & scl_fall;

  // position of the byte now on the bus
  assign at_addr_byte = (byte_idx == BYTE_ADDR);
  assign at_cmd_byte = (byte_idx == BYTE_CMD);
  assign at_low_byte = (byte_idx == BYTE_LOW);
  assign at_high_byte = (byte_idx == BYTE_HIGH);
  assign data_room = (byte_idx < BYTE_EXTRA);

  assign shift_evt = bit_evt & in_shift;
  assign byte_done = shift_evt & (bit_cnt == LAST_BIT);
  // read direction at own address is refused: the device never transmits
  assign own_match = (next_shift[7:1] == own_addr) & (next_shift[0] == WRITE_DIR);
  assign group_match = (next_shift[7:1] == GROUP_ADDR);
  // data bytes are only taken behind the own address, up to the high byte
  assign byte_accept = at_addr_byte ? (own_match | group_match) : (own_hit & data_room);
  assign ack_rise = bit_evt & in_ack_drive;
  assign addr_done = byte_done & at_addr_byte;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_SHIFT: begin
        if (byte_done) begin
          next_state = byte_accept ? ST_ACK_WAIT : ST_IGNORE;
        end
      end
      ST_ACK_WAIT: begin
        if (scl_fall) begin
          next_state = ST_ACK_DRIVE;
        end
      end
      ST_ACK_DRIVE: begin
        if (bit_evt) begin
          next_state = ST_ACK_HOLD;
        end
      end
      ST_ACK_HOLD: begin
        if (scl_fall) begin
          next_state = ST_SHIFT;
        end
      end
      ST_IGNORE: begin
        next_state = ST_IGNORE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (start_evt) begin
      next_state = ST_SHIFT;
    end else if (stop_evt) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || frame_edge) begin
      bit_cnt <= COUNT_RESET;
      shift <= BYTE_RESET;
    end else if (shift_evt) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= next_shift;
    end else if (ack_end) begin
      bit_cnt <= COUNT_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || frame_edge) begin
      byte_idx <= BYTE_ADDR;
    end else if (ack_rise && data_room) begin
      byte_idx <= byte_idx + 3'h1;
    end
  end

  // address outcome, kept for the rest of the frame
  always_ff @(posedge clk_sys) begin
    if (rst || frame_edge) begin
      own_hit <= 1'b0;
      group_hit <= 1'b0;
      group_action_bit <= 1'b0;
    end else if (addr_done) begin
      own_hit <= own_match;
      group_hit <= group_match & ~own_match;
      group_action_bit <= next_shift[0];
    end
  end

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  logic [7:0] command_input;
  logic [7:0] data_low_input;
  logic [7:0] data_high_input;
  logic [7:0] low_pending;
  logic own_ack;
  logic group_ack;
  logic group_update;
  logic group_clear;
  logic stop_update;
  logic stop_seen_own;
  logic command_load;
  logic low_load;
  logic high_load;

  assign own_ack = ack_rise & own_hit;
  assign command_load = own_ack & at_cmd_byte;
  assign low_load = own_ack & at_low_byte;
  assign high_load = own_ack & at_high_byte;
  assign group_ack = ack_rise & group_hit & at_addr_byte;
  assign group_update = group_ack & group_action_bit & command_input[CMD_GROUP_BIT];
  assign group_clear = group_ack & ~group_action_bit;
  assign stop_seen_own = stop_evt & own_hit;
  assign stop_update = stop_seen_own & ~command_input[CMD_GROUP_BIT];

  // the command is written only at its acknowledge, so an interrupted
  // command byte never reaches the register
  always_ff @(posedge clk_sys) begin
    if (rst || group_clear) begin
      command_input <= BYTE_RESET;
    end else if (command_load) begin
      command_input <= shift;
    end
  end

  // low byte waits until the high byte is acknowledged so that a frame
  // broken between them leaves both data registers untouched
  always_ff @(posedge clk_sys) begin
    if (rst || group_clear) begin
      low_pending <= BYTE_RESET;
    end else if (low_load) begin
      low_pending <= shift;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || group_clear) begin
      data_low_input <= BYTE_RESET;
      data_high_input <= BYTE_RESET;
    end else if (high_load) begin
      data_low_input <= low_pending;
      data_high_input <= shift;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [CODE_WIDTH-1:0] input_code;
  logic output_load;

  assign input_code = {data_high_input[HIGH_CODE_BITS-1:0], data_low_input};
  assign output_load = stop_update | group_update;

  always_ff @(posedge clk_sys) begin
    if (rst || group_clear) begin
      dac_code <= {CODE_WIDTH{1'b0}};
      reference_select <= 1'b0;
    end else if (output_load) begin
      dac_code <= input_code;
      reference_select <= command_input[CMD_REF_BIT];
    end
  end

  // power-down leaves the code registers alone
  always_ff @(posedge clk_sys) begin
    if (rst || group_clear) begin
      power_down_select <= 1'b0;
    end else if (stop_seen_own) begin
      power_down_select <= command_input[CMD_POWER_BIT];
    end
  end

  // ----------------------------------------------------------------
  // data line drive and status
  // ----------------------------------------------------------------
  // open-drain: only ever a low, and only across the acknowledge pulse
  assign sda_out = 1'b0;
  assign sda_oe = in_ack_drive | in_ack_hold;
  assign group_update_select = command_input[CMD_GROUP_BIT];
  assign bus_busy = (state != ST_IDLE);

endmodule // dac_smbus_write_slave

`default_nettype wire

// ---- bench/dac_smbus_write_slave_checker.sv ----
// port assertions for the two-wire dac write slave
`timescale 1ns/1ps
`default_nettype none
module dac_smbus_write_slave_checker
  import dac_smbus_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_link,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_select_pin_2,
  input wire logic addr_select_pin_1,
  input wire logic addr_select_pin_0,
  input wire logic [CODE_WIDTH-1:0] dac_code,
  input wire logic reference_select,
  input wire logic power_down_select,
  input wire logic group_update_select,
  input wire logic bus_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_oe_in_frame: assert property (sda_oe |-> bus_busy)
    else $error("data pulled low outside a frame");
  a_oe_low_only: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data driven high");
  a_ack_holds_high: assert property (sda_oe && scl_link |=> sda_oe)
    else $error("ack released during clock high");
  a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_link)
    else $error("ack started with clock high");
  a_ack_release_low: assert property ($fell(sda_oe) |-> !scl_link)
    else $error("ack ended with clock high");
  a_busy_on_start: assert property ($fell(sda_in) && scl_link |-> ##[1:8] bus_busy)
    else $error("start not seen");
  a_busy_off_stop: assert property ($rose(sda_in) && scl_link |-> ##[1:8] !bus_busy)
    else $error("stop not seen");
  a_idle_holds_out: assert property (!bus_busy [*3] |=>
    $stable({dac_code, reference_select, power_down_select, group_update_select}))
    else $error("outputs changed on idle bus");
  a_pd_at_stop: assert property ($rose(power_down_select) |-> ##[0:3] !bus_busy)
    else $error("power-down outside stop");
  cover property (sda_oe);
  cover property ($fell(bus_busy));
  cover property ($changed(dac_code));
endmodule // dac_smbus_write_slave_checker
`default_nettype wire

// ---- bench/smbus_master_model.sv ----
// two-wire bus master model, open-drain data with pull-up
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model #(
  parameter int PH = 640,
  parameter int Q = 128
) (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    #Q sda_drv = b;
    #(PH - Q) scl = 1'b1;
    #PH r = sda_line;
    scl = 1'b0;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    scl = 1'b1;
    #PH sda_drv = 1'b0;
    #PH scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_drv = 1'b0;
    #(PH - Q) scl = 1'b1;
    #PH sda_drv = 1'b1;
    #PH;
  endtask
  task automatic bits(input logic [7:0] b, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(b[i], r);
    end
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    bits(b, 8);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
endmodule // smbus_master_model
`default_nettype wire

// ---- bench/dac_smbus_write_slave_tb.sv ----
// self-checking bench for the two-wire dac write slave
`timescale 1ns/1ps
`default_nettype none
module dac_smbus_write_slave_tb;
  import dac_smbus_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pins = 3'h5;
  logic scl, sda_drv, sda_out, sda_oe, ref_sel, pd_sel, grp_sel, busy, a;
  logic [CODE_WIDTH-1:0] code;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  wire logic sda_line;
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  // pins lag the master so no bus edge lands on a system clock edge
  wire logic scl_pin;
  wire logic sda_pin;
  assign #5 scl_pin = scl;
  assign #5 sda_pin = sda_line;
  always #20 clk_sys = ~clk_sys;
  smbus_master_model u_mst (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  dac_smbus_write_slave u_dut (.clk_sys(clk_sys), .rst(rst), .scl_link(scl_pin), .sda_in(sda_pin),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_2(pins[2]), .addr_select_pin_1(pins[1]),
    .addr_select_pin_0(pins[0]), .dac_code(code), .reference_select(ref_sel),
    .power_down_select(pd_sel), .group_update_select(grp_sel), .bus_busy(busy));
  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic st(input logic [9:0] c, input logic r, input logic p, input logic g);
    chk("dac_code", 16'(code), 16'(c));
    chk("reference_select", 16'(ref_sel), 16'(r));
    chk("power_down_select", 16'(pd_sel), 16'(p));
    chk("group_update_select", 16'(grp_sel), 16'(g));
  endtask
  task automatic fin();
    u_mst.stop();
    repeat (12) @(posedge clk_sys);
  endtask
  // bytes most significant first, acks expected one bit per byte
  task automatic frame(input logic [31:0] b, input int n, input logic [3:0] acks, input logic s);
    logic k;
    u_mst.start();
    for (int i = 0; i < n; i++) begin
      u_mst.wbyte(b[31-8*i -: 8], k);
      chk("ack", 16'(k), 16'(acks[3-i]));
    end
    if (s) begin
      fin();
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    st(10'h000, 1'b0, 1'b0, 1'b0);
    frame(32'h4AF4A5FE, 4, 4'hF, 1'b0);
    chk("bus_busy", 16'(busy), 16'h0001);
    st(10'h000, 1'b0, 1'b0, 1'b0);
    fin();
    chk("bus_busy", 16'(busy), 16'h0000);
    st(10'h2A5, 1'b1, 1'b0, 1'b0);
    frame(32'h4C000000, 2, 4'h0, 1'b1);
    frame(32'h4B000000, 2, 4'h0, 1'b1);
    st(10'h2A5, 1'b1, 1'b0, 1'b0);
    frame(32'h4A001200, 3, 4'hE, 1'b1);
    st(10'h2A5, 1'b0, 1'b0, 1'b0);
    u_mst.start();
    u_mst.wbyte(8'h4A, a);
    chk("ack", 16'(a), 16'h0001);
    u_mst.bits(8'hFF, 4);
    fin();
    st(10'h2A5, 1'b0, 1'b0, 1'b0);
    frame(32'h4A030000, 2, 4'hC, 1'b0);
    st(10'h2A5, 1'b0, 1'b0, 1'b1);
    fin();
    st(10'h2A5, 1'b0, 1'b1, 1'b1);
    frame(32'h4A073C01, 4, 4'hF, 1'b1);
    st(10'h2A5, 1'b0, 1'b1, 1'b1);
    frame(32'hFD000000, 1, 4'h8, 1'b0);
    st(10'h13C, 1'b1, 1'b1, 1'b1);
    fin();
    frame(32'hFC000000, 1, 4'h8, 1'b1);
    st(10'h000, 1'b0, 1'b0, 1'b0);
    pins <= 3'h2;
    repeat (4) @(posedge clk_sys);
    frame(32'h44000000, 2, 4'hC, 1'b1);
    frame(32'h4A000000, 1, 4'h0, 1'b1);
    st(10'h000, 1'b0, 1'b0, 1'b0);
    stop_test();
  end
endmodule // dac_smbus_write_slave_tb
bind dac_smbus_write_slave dac_smbus_write_slave_checker u_chk (.clk_sys, .rst, .scl_link, .sda_in,
  .sda_out, .sda_oe, .addr_select_pin_2, .addr_select_pin_1, .addr_select_pin_0, .dac_code,
  .reference_select, .power_down_select, .group_update_select, .bus_busy);
`default_nettype wire
